// ### shared/cssc_defs.vh
`ifndef CSSC_DEFS_VH
`define CSSC_DEFS_VH
// Pointer and data widths.
`define CSSC_PTR_W 8
`define CSSC_DATA_W 8
// Reset value of the stack pointer; first push lands at 8'h00 after wrap.
`define CSSC_PTR_RESET 8'hFF
// Base and size of the single stack RAM; it starts at address zero.
`define CSSC_RAM_BASE 8'h00
`define CSSC_RAM_DEPTH 256
// Operation codes of the command port.
`define CSSC_OP_NONE 3'h0
`define CSSC_OP_PUSH 3'h1
`define CSSC_OP_POP 3'h2
`define CSSC_OP_LOAD 3'h3
`define CSSC_OP_ADD 3'h4
`define CSSC_OP_CALL 3'h5
`define CSSC_OP_INTR 3'h6
// Low-power mode codes.
`define CSSC_LP_STANDBY 1'b0
`define CSSC_LP_HALT 1'b1
`endif

// ### rtl/cssc_ram.v
`timescale 1ns/100ps
// *****************************************
// Register file / stack RAM
// *****************************************
module cssc_ram (
    // Clock.
    input wire sys_clk,
    // Write port.
    input wire wr_en,
    input wire [7:0] wr_addr,
    input wire [7:0] wr_data,
    // Read ports.
    input wire [7:0] rd_addr_a,
    output wire [7:0] rd_data_a,
    input wire [7:0] rd_addr_b,
    output wire [7:0] rd_data_b
);
    reg [7:0] mem [0:255];

    // Contents hold whenever no write is given, so sleep keeps them.
    always @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    assign rd_data_a = mem[rd_addr_a];
    assign rd_data_b = mem[rd_addr_b];
endmodule // cssc_ram

// ### rtl/cssc_core.v
`timescale 1ns/100ps
`include "cssc_defs.vh"
module cssc_core (
    // Clock and reset.
    input wire sys_clk,
    input wire resetn,
    // Command port.
    input wire cmd_valid,
    input wire [2:0] cmd_op,
    input wire [7:0] cmd_data,
    input wire [7:0] cmd_reg_src,
    input wire [7:0] cmd_reg_dst,
    input wire [15:0] cmd_ret_addr,
    input wire [7:0] condition_flag_register,
    // Low-power control.
    input wire sleep_req,
    input wire sleep_mode,
    input wire wake_req,
    // Status and results.
    output reg cmd_ready,
    output reg cmd_done,
    output reg [7:0] pop_data,
    output reg [7:0] stack_top_pointer,
    output reg cpu_run,
    output reg osc_run,
    output reg timer_run,
    output reg in_sleep
);
    // *****************************************
    // State encoding
    // *****************************************
    // One-hot states; a stray code falls back to idle through the default branch.
    // Idle takes one command a cycle; a call holds the port for a second cycle to push
    // its low byte, and sleep parks the sequencer until wake.
    localparam S_IDLE = 4'b0001;
    localparam S_SLEEP = 4'b0100;
    localparam S_CALL2 = 4'b1000;

    reg [3:0] state;
    reg [7:0] ret_low;
    reg ram_we;
    reg [7:0] ram_waddr;
    reg [7:0] ram_wdata;
    wire [7:0] rd_top;
    wire [7:0] rd_src;
    wire [7:0] rd_dst;
    wire [7:0] ptr_inc;
    wire [7:0] ptr_dec;
    wire [7:0] rd_addr_a;
    wire [7:0] rd_addr_b;

    // *****************************************
    // Pointer arithmetic
    // *****************************************
    // One step of the stack pointer, up for a push and down for a pop.
    // The result keeps eight bits, so FF steps to 00 and back without a size check;
    // the RAM covers all 256 addresses, so no pointer value falls outside it.
    function [7:0] ptr_step;
        input [7:0] ptr;
        input up;
        begin
            if (up) begin
                ptr_step = ptr + 8'h01;
            end else begin
                ptr_step = ptr - 8'h01;
            end
        end
    endfunction

    // Both neighbours of the top are ready every cycle, so a command needs no extra step.
    assign ptr_inc = ptr_step(stack_top_pointer, 1'b1);
    assign ptr_dec = ptr_step(stack_top_pointer, 1'b0);

    // *****************************************
    // Stack and register RAM
    // *****************************************
    // Port A reads the top of stack, or the first operand of an add.
    assign rd_addr_a = (cmd_op == `CSSC_OP_ADD) ? cmd_reg_src : stack_top_pointer;
    // Port B always reads the second operand, which also receives the sum.
    assign rd_addr_b = cmd_reg_dst;
    assign rd_src = rd_top;

    // Single RAM, base 8'h00, any pointer value is legal.
    cssc_ram u_ram (
        .sys_clk(sys_clk),
        .wr_en(ram_we),
        .wr_addr(ram_waddr),
        .wr_data(ram_wdata),
        .rd_addr_a(rd_addr_a),
        .rd_data_a(rd_top),
        .rd_addr_b(rd_addr_b),
        .rd_data_b(rd_dst)
    );

    // *****************************************
    // Sequencer
    // *****************************************
    // A RAM write lands one edge after its command, so a pop or add that reads a byte
    // pushed in the cycle before would see the old value; callers leave one idle cycle.
    // Main sequencer: one command per idle cycle, sleep only between commands.
    always @(posedge sys_clk) begin
        // RAM keeps its contents; the pointer, the state, the flags, pop_data and the write controls return.
        if (!resetn) begin
            state <= S_IDLE;
            stack_top_pointer <= `CSSC_PTR_RESET;
            ram_we <= 1'b0;
            ram_waddr <= `CSSC_RAM_BASE;
            ram_wdata <= 8'h00;
            ret_low <= 8'h00;
            cmd_ready <= 1'b1;
            cmd_done <= 1'b0;
            pop_data <= 8'h00;
            cpu_run <= 1'b1;
            osc_run <= 1'b1;
            timer_run <= 1'b1;
            in_sleep <= 1'b0;
        end else begin
            ram_we <= 1'b0;
            cmd_done <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (cmd_valid) begin
                        case (cmd_op)
                            `CSSC_OP_PUSH: begin
                                // Pointer steps first; write lands at new top.
                                stack_top_pointer <= ptr_inc;
                                ram_we <= 1'b1;
                                ram_waddr <= ptr_inc;
                                ram_wdata <= cmd_data;
                                cmd_done <= 1'b1;
                            end
                            `CSSC_OP_POP: begin
                                // Top is read before the pointer moves.
                                pop_data <= rd_top;
                                stack_top_pointer <= ptr_dec;
                                cmd_done <= 1'b1;
                            end
                            `CSSC_OP_LOAD: begin
                                stack_top_pointer <= cmd_data;
                                cmd_done <= 1'b1;
                            end
                            `CSSC_OP_ADD: begin
                                // No accumulator: result goes to second register.
                                ram_we <= 1'b1;
                                ram_waddr <= cmd_reg_dst;
                                ram_wdata <= rd_src + rd_dst;
                                cmd_done <= 1'b1;
                            end
                            `CSSC_OP_CALL: begin
                                // High byte first, low byte next cycle.
                                stack_top_pointer <= ptr_inc;
                                ram_we <= 1'b1;
                                ram_waddr <= ptr_inc;
                                ram_wdata <= cmd_ret_addr[15:8];
                                ret_low <= cmd_ret_addr[7:0];
                                cmd_ready <= 1'b0;
                                state <= S_CALL2;
                            end
                            `CSSC_OP_INTR: begin
                                // Status byte pushed like any other.
                                stack_top_pointer <= ptr_inc;
                                ram_we <= 1'b1;
                                ram_waddr <= ptr_inc;
                                ram_wdata <= condition_flag_register;
                                cmd_done <= 1'b1;
                            end
                            default: begin
                                cmd_done <= 1'b0;
                            end
                        endcase
                    end else if (sleep_req) begin
                        // Only taken with no command in flight.
                        state <= S_SLEEP;
                        cmd_ready <= 1'b0;
                        cpu_run <= 1'b0;
                        in_sleep <= 1'b1;
                        timer_run <= (sleep_mode == `CSSC_LP_STANDBY);
                        osc_run <= (sleep_mode == `CSSC_LP_STANDBY);
                    end
                end
                S_CALL2: begin
                    stack_top_pointer <= ptr_inc;
                    ram_we <= 1'b1;
                    ram_waddr <= ptr_inc;
                    ram_wdata <= ret_low;
                    cmd_done <= 1'b1;
                    cmd_ready <= 1'b1;
                    state <= S_IDLE;
                end
                S_SLEEP: begin
                    // No RAM writes and pointer held while asleep.
                    if (wake_req) begin
                        state <= S_IDLE;
                        cmd_ready <= 1'b1;
                        cpu_run <= 1'b1;
                        osc_run <= 1'b1;
                        timer_run <= 1'b1;
                        in_sleep <= 1'b0;
                    end
                end
                default: begin
                    state <= S_IDLE;
                    cmd_ready <= 1'b1;
                end
            endcase
        end
    end
endmodule // cssc_core

// ### test/cssc_stack_model.sv
`timescale 1ns/100ps
module cssc_stack_model;
    // ****************
    // Reference stack
    // ****************
    // Full 256-byte space, so any stack placement is modelled.
    reg [7:0] mem [0:255];
    reg [7:0] ptr = 8'hFF;
    // The pointer moves first, then the byte lands on the new top.
    task m_push(input [7:0] d);
        begin
            ptr = ptr + 8'h01;
            mem[ptr] = d;
        end
    endtask
    // The top is read before the pointer steps back.
    task m_pop(output [7:0] d);
        begin
            d = mem[ptr];
            ptr = ptr - 8'h01;
        end
    endtask
endmodule // cssc_stack_model

// ### test/cssc_core_sva.sv
`timescale 1ns/100ps
`include "cssc_defs.vh"
module cssc_chk (
    // Clock and reset.
    input wire sys_clk,
    input wire resetn,
    // Requests.
    input wire cmd_valid,
    input wire [2:0] cmd_op,
    input wire [7:0] cmd_data,
    input wire sleep_req,
    input wire sleep_mode,
    input wire wake_req,
    // Status.
    input wire cmd_ready,
    input wire cmd_done,
    input wire [7:0] stack_top_pointer,
    input wire cpu_run,
    input wire osc_run,
    input wire timer_run,
    input wire in_sleep
);
    // ************
    // Properties
    // ************
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // A command is taken only when offered, accepted and awake.
    wire take = cmd_valid && cmd_ready && !in_sleep;
    wire [7:0] top_ptr = stack_top_pointer;
    push_step_a: assert property (take && cmd_op == `CSSC_OP_PUSH |=>
        top_ptr == $past(top_ptr) + 8'h01 && cmd_done) else $error("push step wrong");
    pop_step_a: assert property (take && cmd_op == `CSSC_OP_POP |=>
        top_ptr == $past(top_ptr) - 8'h01 && cmd_done) else $error("pop step wrong");
    load_ptr_a: assert property (take && cmd_op == `CSSC_OP_LOAD |=>
        top_ptr == $past(cmd_data)) else $error("pointer load wrong");
    call_two_a: assert property (take && cmd_op == `CSSC_OP_CALL |->
        ##2 top_ptr == $past(top_ptr, 2) + 8'h02) else $error("call push count wrong");
    sleep_entry_a: assert property (
        sleep_req && !cmd_valid && cmd_ready && !in_sleep |=>
        in_sleep && osc_run == !$past(sleep_mode) && timer_run == osc_run)
        else $error("sleep entry wrong");
    cpu_stop_a: assert property (in_sleep |-> !cpu_run && !cmd_ready)
        else $error("cpu active in sleep");
    sleep_quiet_a: assert property (in_sleep |-> !cmd_done)
        else $error("command finished in sleep");
    sleep_hold_a: assert property (in_sleep && !wake_req |=>
        in_sleep && $stable(top_ptr)) else $error("state lost in sleep");
    wake_run_a: assert property (in_sleep && wake_req |=>
        cpu_run && osc_run && timer_run && cmd_ready) else $error("wake failed");
    cmd_first_a: assert property (sleep_req && take |=> !in_sleep)
        else $error("sleep cut a command");
endmodule // cssc_chk
bind cssc_core cssc_chk i_chk (.sys_clk, .resetn, .cmd_valid, .cmd_op, .cmd_data,
    .sleep_req, .sleep_mode, .wake_req, .cmd_ready, .cmd_done, .stack_top_pointer,
    .cpu_run, .osc_run, .timer_run, .in_sleep);

// ### test/cssc_core_tb.sv
`timescale 1ns/100ps
`include "cssc_defs.vh"
module cssc_core_tb;
    reg sys_clk, resetn, cmd_valid, sleep_req, sleep_mode, wake_req;
    reg [2:0] cmd_op;
    reg [7:0] cmd_data, cmd_reg_src, cmd_reg_dst, condition_flag_register, e;
    reg [15:0] cmd_ret_addr;
    wire cmd_ready, cmd_done, cpu_run, osc_run, timer_run, in_sleep;
    wire [7:0] pop_data, stack_top_pointer;
    integer n_fail = 0, checked = 0, i;
    cssc_core i_dut (.sys_clk, .resetn, .cmd_valid, .cmd_op, .cmd_data, .cmd_reg_src,
        .cmd_reg_dst, .cmd_ret_addr, .condition_flag_register, .sleep_req, .sleep_mode,
        .wake_req, .cmd_ready, .cmd_done, .pop_data, .stack_top_pointer, .cpu_run,
        .osc_run, .timer_run, .in_sleep);
    cssc_stack_model i_model ();
    // *******
    // Tasks
    // *******
    task chk(input [7:0] seen, input [7:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task results;
        begin
            $display("checks %0d mismatches %0d", checked, n_fail);
            if (n_fail == 0 && checked > 0) begin
                $display("TB: PASS");
            end else begin
                $display("TB: FAIL");
            end
            $finish;
        end
    endtask
    // One command, mirrored in the model; the call answers a cycle later.
    task do_cmd(input [2:0] op, input [7:0] d, input s);
        begin
            @(posedge sys_clk);
            {cmd_op, cmd_data, cmd_valid, sleep_req} <= {op, d, 1'b1, s};
            @(posedge sys_clk);
            cmd_valid <= 1'b0;
            case (op)
                `CSSC_OP_PUSH: i_model.m_push(d);
                `CSSC_OP_POP: i_model.m_pop(e);
                `CSSC_OP_LOAD: i_model.ptr = d;
                `CSSC_OP_ADD: i_model.mem[1] = i_model.mem[1] + i_model.mem[0];
                `CSSC_OP_CALL: begin
                    i_model.m_push(cmd_ret_addr[15:8]);
                    i_model.m_push(cmd_ret_addr[7:0]);
                end
                default: i_model.m_push(condition_flag_register);
            endcase
            i = 0;
            #1;
            while (cmd_done !== 1'b1 && i < 4) begin
                @(posedge sys_clk);
                #1 i = i + 1;
            end
            chk(cmd_done, 8'h01);
            chk(stack_top_pointer, i_model.ptr);
            if (op == `CSSC_OP_POP) chk(pop_data, e);
        end
    endtask
    // *********
    // Scenarios
    // *********
    task s_stack;
        begin
            do_cmd(`CSSC_OP_PUSH, 8'hA5, 0);
            do_cmd(`CSSC_OP_PUSH, 8'h3C, 0);
            repeat (2) do_cmd(`CSSC_OP_POP, 8'h00, 0);
            do_cmd(`CSSC_OP_LOAD, 8'hFE, 0);
            do_cmd(`CSSC_OP_PUSH, 8'h11, 0);
            do_cmd(`CSSC_OP_PUSH, 8'h22, 0);
            do_cmd(`CSSC_OP_CALL, 8'h00, 0);
            do_cmd(`CSSC_OP_INTR, 8'h00, 0);
            repeat (5) do_cmd(`CSSC_OP_POP, 8'h00, 0);
            do_cmd(`CSSC_OP_LOAD, 8'hFF, 0);
            do_cmd(`CSSC_OP_PUSH, 8'h07, 0);
            do_cmd(`CSSC_OP_PUSH, 8'h09, 0);
            do_cmd(`CSSC_OP_ADD, 8'h00, 0);
            do_cmd(`CSSC_OP_POP, 8'h00, 0);
            // An unused operation code must leave the stack alone.
            @(posedge sys_clk);
            {cmd_op, cmd_valid} <= {3'h7, 1'b1};
            @(posedge sys_clk);
            cmd_valid <= 1'b0;
            #1 chk(cmd_done, 8'h00);
            chk(stack_top_pointer, i_model.ptr);
        end
    endtask
    // Sleep is asked together with a push, so it must wait for it.
    task s_sleep(input m);
        begin
            @(posedge sys_clk);
            sleep_mode <= m;
            do_cmd(`CSSC_OP_PUSH, 8'hC3, 1);
            @(posedge sys_clk);
            sleep_req <= 1'b0;
            #1 chk(in_sleep, 8'h01);
            chk(cpu_run, 8'h00);
            chk(osc_run, m == `CSSC_LP_STANDBY);
            chk(timer_run, m == `CSSC_LP_STANDBY);
            chk(cmd_ready, 8'h00);
            // A push offered while asleep must be ignored.
            repeat (2) @(posedge sys_clk);
            cmd_valid <= 1'b1;
            repeat (2) @(posedge sys_clk);
            cmd_valid <= 1'b0;
            #1 chk(stack_top_pointer, i_model.ptr);
            chk(cmd_done, 8'h00);
            @(posedge sys_clk);
            wake_req <= 1'b1;
            @(posedge sys_clk);
            wake_req <= 1'b0;
            #1 chk(cpu_run, 8'h01);
            chk(cmd_ready, 8'h01);
            chk(osc_run, 8'h01);
            chk(timer_run, 8'h01);
            chk(in_sleep, 8'h00);
            do_cmd(`CSSC_OP_POP, 8'h00, 0);
        end
    endtask
    // Mid-run reset from halt: flags and pointer return, the stack RAM is kept.
    task s_reset;
        begin
            @(posedge sys_clk);
            sleep_req <= 1'b1;
            @(posedge sys_clk);
            {sleep_req, resetn} <= 2'b00;
            #1 chk(in_sleep, 8'h01);
            chk(osc_run, 8'h00);
            @(posedge sys_clk);
            resetn <= 1'b1;
            #1 chk(stack_top_pointer, `CSSC_PTR_RESET);
            chk({in_sleep, cpu_run, osc_run, timer_run, cmd_ready, cmd_done}, 8'h1E);
            chk(pop_data, 8'h00);
            i_model.ptr = `CSSC_PTR_RESET;
            do_cmd(`CSSC_OP_PUSH, 8'h5E, 0);
            do_cmd(`CSSC_OP_POP, 8'h00, 0);
        end
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Watchdog well beyond the roughly 80 cycles the run needs.
    initial begin
        #100000;
        n_fail = n_fail + 1;
        results;
    end
    initial begin
        {resetn, cmd_valid, cmd_op, cmd_data, sleep_req, sleep_mode, wake_req} = 0;
        {cmd_reg_src, cmd_reg_dst, cmd_ret_addr} = {8'h00, 8'h01, 16'h1234};
        condition_flag_register = 8'h5A;
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        s_stack;
        s_sleep(`CSSC_LP_STANDBY);
        s_sleep(`CSSC_LP_HALT);
        s_reset;
        results;
    end
endmodule // cssc_core_tb
